// ---- hdl/dsp_dma_channel_sequencer.sv ----
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "dma_seq_defines.svh"

// Notes on behaviour
// - Host sets valid flag; idle sequencer polls it.
// - Finish pulses clear bit and shows done.
// - Host only sets flag; sequencer only clears.
// - Low four bits pick operation; top bit assists.
// - Six in, seven out, one initialize.
// - Qualifier high adds address passes after in.
// - Command re-read after transfer for pass count.
// - Multiway branch on low four command bits.
// - Wait on sequence end input for completion.
// - Output half leaves through pipeline register.
// - Bits four to zero address lookup memory.
// - Bits eight to six instruct generators.
// - Bit nine gates generator counting.
// - Bit ten enables bus transfers.
// - Bit twelve zero fill overrides bus enable.
// - Bit fifteen tells host command done.
// - Bits fourteen, thirteen select generator clock.
// - Start then length lookup seed generators.
// - Generators count until word count expires.
// - Assist passes count addresses, bus kept off.
// - Sixteen-bit port moves and initializes data.
// - Clock codes 00,01,11; done active low.
// - Instruction codes for write, reinit, loads, count.
// - Reinitialize between passes; notify after all.
module dsp_dma_channel_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sequence_end_input,
  output logic [15:0] user_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal access.
  localparam logic [1:0] RESP_DECERR = 2'h3; // Unmapped address.

  logic [7:0] awaddr_r; // Captured write address.
  logic [31:0] wdata_r; // Captured write data.
  logic [3:0] wstrb_r; // Captured byte enables.
  logic awready_r; // Low once an address is held.
  logic wready_r; // Low once data is held.
  logic bvalid_r; // Write response pending.
  logic [1:0] bresp_r; // Write response code.
  logic arready_r; // Low while a read answer is out.
  logic rvalid_r; // Read answer pending.
  logic [31:0] rdata_r; // Read answer data.
  logic [1:0] rresp_r; // Read answer code.
  logic wr_fire; // Both halves of a write are held.
  logic [4:0] cmd_r; // Host command register.
  logic valid_r; // Valid-command flag.
  logic set_valid; // Host write that sets the flag.
  logic [4:0] cmd_lat_r; // Command held for the running job.
  logic seq_end_meta_r; // First synchroniser stage.
  logic seq_end_s_r; // Synchronised sequence end.
  dma_seq_pkg::seq_state_t state_r; // Current step.
  logic [3:0] pass_r; // Assist passes still to run.
  logic [15:0] word_nxt; // Output word for this step.
  logic [15:0] word_r; // Pipeline register on the outputs.
  logic assist; // Job asks for DSP passes.
  down_count_if wcnt (); // Wait-state counter link.

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Packs the eight output fields; bit five is always low.
  function automatic logic [15:0] make_word(
    input logic done_n, input logic [1:0] ck, input logic zen_n,
    input logic clr_n, input logic ben_n, input logic cnt_n,
    input logic [2:0] instr, input logic [4:0] addr);
    make_word = {done_n, ck, zen_n, clr_n, ben_n, cnt_n, instr, 1'b0,
                 addr};
  endfunction : make_word

  // Start-address lookup entry for each command code.
  function automatic logic [4:0] start_addr(input logic [3:0] code);
    if (code <= `CMD_DTI_LAST)
      start_addr = {1'b0, code};
    else if (code < `CMD_DTO_LAST)
      start_addr = 5'(code - 4'h6);
    else if (code == `CMD_DTO_LAST)
      start_addr = 5'h01;
    else
      start_addr = `LK_NONE;
  endfunction : start_addr

  // Block-length lookup entry for each command code.
  function automatic logic [4:0] length_addr(input logic [3:0] code);
    logic [2:0] idx;
    case (code)
      4'h0: idx = 3'h0;
      4'h1, 4'h3: idx = 3'h1;
      4'h2, 4'h4: idx = 3'h2;
      4'h5: idx = 3'h3;
      4'h6, 4'ha: idx = 3'h4;
      4'h7, 4'hb: idx = 3'h5;
      4'h8, 4'hc: idx = 3'h6;
      default: idx = 3'h7;
    endcase
    length_addr = `LK_WC_BASE | {2'h0, idx};
  endfunction : length_addr

  // True for codes that name no operation of the fourteen.
  function automatic logic unused_code(input logic [3:0] code);
    unused_code = (code > `CMD_DTO_LAST) && (code != `CMD_MEMINIT);
  endfunction : unused_code

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  assign wr_fire = !awready_r && !wready_r && !bvalid_r;

  // Address and data are taken in either order; the response follows
  // once both are held, and readiness returns when it is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        // Only the command and flag words accept writes.
        if (awaddr_r == `OFS_CMD || awaddr_r == `OFS_FLAG)
          bresp_r <= RESP_OKAY;
        else
          bresp_r <= RESP_DECERR;
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Command register; the sequencer reads its latched copy, so a
  // write during a job only affects the next one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_r <= 5'h00;
    else if (wr_fire && awaddr_r == `OFS_CMD && wstrb_r[0])
      cmd_r <= wdata_r[4:0];
  end

  assign set_valid = wr_fire && awaddr_r == `OFS_FLAG && wstrb_r[0]
                     && wdata_r[0];

  // Valid flag: the host can only set it, the sequencer only clears
  // it, and a set in the clearing cycle wins so no command is lost.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      valid_r <= 1'b0;
    else if (set_valid)
      valid_r <= 1'b1;
    else if (state_r == dma_seq_pkg::ST_CLEAR)
      valid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  // One read at a time; the answer stands until rready.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      if (s_axi_araddr == `OFS_CMD)
        rdata_r <= {27'h000_0000, cmd_r};
      else if (s_axi_araddr == `OFS_FLAG)
        rdata_r <= {31'h0000_0000, valid_r};
      else if (s_axi_araddr == `OFS_STATUS)
        rdata_r <= {6'h00, state_r, pass_r, seq_end_s_r, valid_r,
                    word_r};
      else
      begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= RESP_DECERR;
      end
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence end synchroniser.

  // The generators run off a shifted clock, so their end pin is
  // treated as foreign and passes two flops before use.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_end_meta_r <= 1'b0;
      seq_end_s_r <= 1'b0;
    end
    else
    begin
      seq_end_meta_r <= sequence_end_input;
      seq_end_s_r <= seq_end_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait-state counter.

  // Loaded while the length is seeded, counted down before transfer.
  assign wcnt.load = (state_r == dma_seq_pkg::ST_LDWC);
  assign wcnt.load_val = (cmd_lat_r[3:0] <= `CMD_DTI_LAST) ? `WAIT_DTI
                         : `WAIT_DTO;
  assign wcnt.dec = (state_r == dma_seq_pkg::ST_WAIT);

  down_counter u_wait (
    .aclk (aclk),
    .aresetn (aresetn),
    .cif (wcnt.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer steps.

  assign assist = cmd_lat_r[4] && (cmd_lat_r[3:0] <= `CMD_DTI_LAST);

  // One step per clock; each step's output word leaves one clock later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= dma_seq_pkg::ST_IDLE;
      cmd_lat_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        dma_seq_pkg::ST_IDLE:
          if (valid_r)
          begin
            cmd_lat_r <= cmd_r;
            state_r <= dma_seq_pkg::ST_LDAD;
          end
        dma_seq_pkg::ST_LDAD:
          // Multiway branch on the low command bits.
          if (unused_code(cmd_lat_r[3:0]))
            state_r <= dma_seq_pkg::ST_CLEAR;
          else
            state_r <= dma_seq_pkg::ST_LDWC;
        dma_seq_pkg::ST_LDWC:
          if (cmd_lat_r[3:0] == `CMD_MEMINIT)
            state_r <= dma_seq_pkg::ST_ZFILL;
          else
            state_r <= dma_seq_pkg::ST_WAIT;
        dma_seq_pkg::ST_WAIT:
          if (wcnt.zero)
            state_r <= dma_seq_pkg::ST_XFER;
        dma_seq_pkg::ST_XFER:
          if (seq_end_s_r && assist)
            state_r <= dma_seq_pkg::ST_REIN;
          else if (seq_end_s_r)
            state_r <= dma_seq_pkg::ST_CLEAR;
        dma_seq_pkg::ST_ZFILL:
          if (seq_end_s_r)
            state_r <= dma_seq_pkg::ST_CLEAR;
        dma_seq_pkg::ST_REIN:
          // The end of the previous count is still in the synchroniser;
          // a pass entered before it drains would end at once.
          if (!seq_end_s_r)
            state_r <= dma_seq_pkg::ST_PASS;
        dma_seq_pkg::ST_PASS:
          if (seq_end_s_r && pass_r == `PASS_ONE)
            state_r <= dma_seq_pkg::ST_CLEAR;
          else if (seq_end_s_r)
            state_r <= dma_seq_pkg::ST_REIN;
        default:
          state_r <= dma_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Pass counter: the command is read again at the end of the
  // transfer to find how many assist passes to run.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pass_r <= 4'h0;
    else if (state_r == dma_seq_pkg::ST_XFER && seq_end_s_r)
      pass_r <= `PASS_ONE + {2'h0, cmd_lat_r[1:0]};
    else if (state_r == dma_seq_pkg::ST_PASS && seq_end_s_r)
      pass_r <= pass_r - `PASS_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word per step.

  // Enables are active low; the generator clock is held off when idle.
  always_comb
  begin
    word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                         `GI_ENCT, `LK_NONE);
    case (state_r)
      dma_seq_pkg::ST_IDLE:
        word_nxt = make_word(1'b0, `CK_OFF, 1'b1, 1'b1, 1'b1, 1'b1,
                             `GI_ENCT, `LK_NONE);
      dma_seq_pkg::ST_LDAD:
        if (unused_code(cmd_lat_r[3:0]))
          word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                               `GI_REIN, `LK_NONE);
        else
          word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                               `GI_LDAD, start_addr(cmd_lat_r[3:0]));
      dma_seq_pkg::ST_LDWC:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                             `GI_LDWC, length_addr(cmd_lat_r[3:0]));
      dma_seq_pkg::ST_XFER:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b0, 1'b0,
                             `GI_ENCT, `LK_NONE);
      dma_seq_pkg::ST_ZFILL:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b0, 1'b1, 1'b1, 1'b0,
                             `GI_ENCT, `LK_NONE);
      dma_seq_pkg::ST_REIN:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                             `GI_REIN, `LK_NONE);
      dma_seq_pkg::ST_PASS:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b0,
                             `GI_ENCT, `LK_NONE);
      dma_seq_pkg::ST_CLEAR:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b0, 1'b1, 1'b1,
                             `GI_ENCT, `LK_NONE);
      default:
        word_nxt = make_word(1'b1, `CK_SYS, 1'b1, 1'b1, 1'b1, 1'b1,
                             `GI_ENCT, `LK_NONE);
    endcase
  end

  // Pipeline register in front of the user output lines.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      word_r <= `WORD_RST;
    else
      word_r <= word_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Port drive.

  assign user_out = word_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clear_step;
    state_r == dma_seq_pkg::ST_CLEAR && !set_valid;
  endsequence

  sequence s_xfer_end;
    state_r == dma_seq_pkg::ST_XFER ##0 seq_end_s_r;
  endsequence

  property p_clear_pulse;
    s_clear_step |=> !valid_r && !word_r[`P_CLR]
      ##1 !word_r[`P_DONE] && word_r[`P_CLR];
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("clear step did not pulse clear and show done");

  property p_start;
    state_r == dma_seq_pkg::ST_IDLE && valid_r
      |=> state_r == dma_seq_pkg::ST_LDAD && cmd_lat_r == $past(cmd_r);
  endproperty
  a_start: assert property (p_start)
    else $error("valid flag did not start the command");

  property p_spare_low;
    !word_r[`P_SPARE];
  endproperty
  a_spare_low: assert property (p_spare_low)
    else $error("spare output bit driven high");

  property p_done_idle;
    state_r != dma_seq_pkg::ST_IDLE |=> word_r[`P_DONE];
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("done shown while a command runs");

  property p_zero_fill;
    !word_r[`P_ZEN] |-> word_r[`P_BEN] && !word_r[`P_CNT];
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("zero fill with bus enable or without count");

  property p_pass_bus_off;
    state_r == dma_seq_pkg::ST_PASS
      |=> word_r[`P_BEN] && !word_r[`P_CNT];
  endproperty
  a_pass_bus_off: assert property (p_pass_bus_off)
    else $error("assist pass moved bus data");

  property p_xfer_end;
    s_xfer_end |=> state_r == (assist ? dma_seq_pkg::ST_REIN
                                      : dma_seq_pkg::ST_CLEAR);
  endproperty
  a_xfer_end: assert property (p_xfer_end)
    else $error("transfer end took the wrong path");

  property p_rein_between;
    state_r == dma_seq_pkg::ST_PASS && seq_end_s_r && pass_r > `PASS_ONE
      |=> state_r == dma_seq_pkg::ST_REIN ##1 word_r[8:6] == `GI_REIN;
  endproperty
  a_rein_between: assert property (p_rein_between)
    else $error("passes not separated by reinitialize");

endmodule : dsp_dma_channel_sequencer

// ---- hdl/dma_seq_defines.svh ----
`ifndef DMA_SEQ_DEFINES_SVH
`define DMA_SEQ_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave.
`define OFS_CMD 8'h00
`define OFS_FLAG 8'h04
`define OFS_STATUS 8'h08

// Bit positions inside the 16-bit user output word.
`define P_DONE 15
`define P_ZEN 12
`define P_CLR 11
`define P_BEN 10
`define P_CNT 9
`define P_SPARE 5

// Generator clock source selections.
`define CK_SYS 2'h0
`define CK_INV 2'h1
`define CK_OFF 2'h3

// Generator instruction codes.
`define GI_WRCR 3'h0
`define GI_REIN 3'h4
`define GI_LDAD 3'h5
`define GI_LDWC 3'h6
`define GI_ENCT 3'h7

// Command groups on the low four command bits.
`define CMD_DTI_LAST 4'h5
`define CMD_DTO_LAST 4'hc
`define CMD_MEMINIT 4'hf

// Lookup addresses and idle lookup address.
`define LK_NONE 5'h1f
`define LK_WC_BASE 5'h08

// Wait states before a transfer, and pass count base.
`define WAIT_DTI 8'h04
`define WAIT_DTO 8'h06
`define PASS_ONE 4'h1

// Output word shown while reset is held.
`define WORD_RST 16'hfe00

`endif

// ---- hdl/dma_seq_pkg.sv ----
package dma_seq_pkg;

  // Sequencer steps, one per kind of microinstruction.
  typedef enum logic [3:0] {
    ST_IDLE, ST_LDAD, ST_LDWC, ST_WAIT, ST_XFER,
    ST_ZFILL, ST_REIN, ST_PASS, ST_CLEAR
  } seq_state_t;

endpackage : dma_seq_pkg

// ---- hdl/down_count_if.sv ----
`timescale 1ns/1ns

// Load and step controls for the wait-state counter.
interface down_count_if;
  logic load;
  logic [7:0] load_val;
  logic dec;
  logic zero;
  modport ctrl (output load, output load_val, output dec, input zero);
  modport cnt (input load, input load_val, input dec, output zero);
endinterface : down_count_if

// ---- hdl/down_counter.sv ----
`timescale 1ns/1ns

// Loadable down counter that stops at zero.
module down_counter (
  input wire logic aclk,
  input wire logic aresetn,
  down_count_if.cnt cif
);

  // Current count; zero means the wait is over.
  logic [7:0] count_r;

  // Load wins over decrement so a fresh wait always starts full.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= 8'h00;
    else if (cif.load)
      count_r <= cif.load_val;
    else if (cif.dec && count_r != 8'h00)
      count_r <= count_r - 8'h01;
  end

  assign cif.zero = (count_r == 8'h00);

endmodule : down_counter

// ---- verif/addr_gen_model.sv ----
`timescale 1ns/1ns

// Stand-in for the address generators on the far side of user_out.
module addr_gen_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] user_out,
  input wire logic [7:0] span,
  output logic sequence_end_input
);
  logic [7:0] words_r = 8'h00; // Words emitted in this run.
  logic end_r = 1'h0; // Completion level towards the sequencer.
  assign sequence_end_input = end_r;
  // Count only with the gate on and a clock selected. Completion drops
  // one clock after the gate goes off; the sequencer's synchroniser still holds it two clocks longer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || user_out[9])
    begin
      words_r <= 8'h00;
      end_r <= 1'h0;
    end
    else if (user_out[14:13] != 2'h3)
    begin
      if (words_r >= span)
        end_r <= 1'h1;
      else
        words_r <= words_r + 8'h01;
    end
  end
endmodule : addr_gen_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns

// Self-checking bench for the DMA channel sequencer.
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sequence_end_input;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] user_out;
  logic [7:0] span = 8'h04; // Words the generator model emits per run.
  logic rec = 1'h0; // Monitor records while a job is under way.
  logic [15:0] q = 16'h0000; // Word of the previous cycle.
  // Job tallies: 0 counting phases, 1 with bus on, 2 with zero fill,
  // 3 reinit entries, 4 start lookups, 5 length lookups, 6 wait
  // cycles, 7 transfer cycles, 8 clear pulses, 9 illegal words.
  int cn[10];
  int clr_w = 0;
  int mismatches = 0;
  int compares = 0;

  dsp_dma_channel_sequencer dsp_dma_channel_sequencer_inst (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sequence_end_input, .user_out);
  addr_gen_model addr_gen_model_inst (.aclk, .aresetn, .user_out, .span,
    .sequence_end_input);

  always #20 aclk = ~aclk;

  //////////////////////////////////////////////////////////////////////
  // Watches every word; the clear pulse must last exactly one cycle.
  always @(posedge aclk)
  begin
    if (rec)
    begin
      if (user_out[9] === 1'h0 && q[9] === 1'h1)
      begin
        cn[0]++;
        if (user_out[10] === 1'h0) cn[1]++;
        if (user_out[12] === 1'h0) cn[2]++;
      end
      if (user_out[8:6] !== q[8:6] && user_out[8:6] === 3'h4) cn[3]++;
      if (user_out[8:6] !== q[8:6] && user_out[8:6] === 3'h5) cn[4]++;
      if (user_out[8:6] !== q[8:6] && user_out[8:6] === 3'h6) cn[5]++;
      if (user_out[15:6] === 10'h27f) cn[6]++;
      if (user_out[10:9] === 2'h0) cn[7]++;
      if (user_out[11] === 1'h0)
        clr_w++;
      else if (clr_w > 0)
      begin
        cn[8]++;
        if (clr_w != 1) cn[9]++;
        clr_w = 0;
      end
      // Spare bit low, clock running while busy, zero fill never with bus.
      if (user_out[5] !== 1'h0 || user_out[12] === user_out[10]
          && user_out[10] === 1'h0 || user_out[15] === 1'h1
          && user_out[14:13] !== 2'h0) cn[9]++;
    end
    q <= user_out;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int exp, input string what);
    compares++;
    if (got != exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  // Write with address and data offered together; held until taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // No answer time is assumed; only the watchdog ends a hang.
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk_val({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk_val(s_axi_rdata, ed, "read data");
    chk_val({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
  endtask : axi_rd

  // Issues one command and follows it until done; poke tries to clear.
  task automatic run_job(input logic [4:0] cmd, input logic [7:0] sp,
    input bit poke);
    int n;
    span <= sp;
    cn = '{default: 0};
    rec = 1'h1;
    axi_wr(8'h00, {27'h0, cmd}, 2'h0);
    axi_wr(8'h04, 32'h0000_0001, 2'h0);
    for (n = 0; n < 20 && user_out[15] !== 1'h1; n++) @(posedge aclk);
    chk_val({31'h0, user_out[15]}, 32'h0000_0001, "job start");
    if (poke)
    begin
      axi_wr(8'h04, 32'h0000_0000, 2'h0);
      axi_rd(8'h04, 32'h0000_0001, 2'h0);
    end
    for (n = 0; n < 3000 && user_out[15] !== 1'h0; n++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    rec = 1'h0;
    axi_rd(8'h04, 32'h0000_0000, 2'h0);
    chk_val({16'h0, user_out}, 32'h0000_7fdf, "idle word");
  endtask : run_job

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (10) @(posedge aclk);
    chk_val({16'h0, user_out}, 32'h0000_fe00, "reset word");
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    axi_rd(8'h08, 32'h0000_7fdf, 2'h0);
    axi_wr(8'h00, 32'hffff_ffff, 2'h0);
    axi_rd(8'h00, 32'h0000_001f, 2'h0);
    axi_wr(8'h0c, 32'h0000_0001, 2'h3);
    axi_rd(8'h0c, 32'h0000_0000, 2'h3);
    repeat (20) @(posedge aclk);
    chk_val({16'h0, user_out}, 32'h0000_7fdf, "no flag");
  endtask : t_reset

  // Every code of the low four bits, without the qualifier.
  task automatic t_codes;
    int c;
    int w0;
    for (c = 0; c < 16; c++)
    begin
      run_job(c[4:0], 8'h04, 1'b0);
      chk_cnt(cn[0], int'(c < 13 || c == 15), "phases");
      chk_cnt(cn[1], int'(c < 13), "bus phases");
      chk_cnt(cn[2], int'(c == 15), "fill phases");
      chk_cnt(cn[4], int'(c < 13 || c == 15), "start");
      chk_cnt(cn[5], int'(c < 13 || c == 15), "length");
      chk_cnt(cn[8], 1, "clear pulses");
      chk_cnt(cn[9], 0, "illegal words");
      chk_cnt(int'(cn[7] >= 4), int'(c < 13), "transfer");
      chk_cnt(cn[3], int'(c == 13 || c == 14), "reinit");
      if (c == 0) chk_cnt(cn[6], 5, "in wait states");
      if (c == 0) w0 = cn[6];
      if (c == 6) chk_cnt(cn[6] - w0, 2, "wait states");
    end
  endtask : t_codes

  // Qualifier set on every transfer-in code: extra dummy passes.
  task automatic t_assist;
    int k;
    for (k = 0; k < 6; k++)
    begin
      run_job({1'h1, k[3:0]}, 8'h03, 1'b0);
      chk_cnt(cn[0], (k & 3) + 2, "passes");
      chk_cnt(cn[1], 1, "bus phases");
      chk_cnt(cn[3], (k & 3) + 1, "reinits");
      chk_cnt(cn[8], 1, "one notice");
      chk_cnt(cn[9], 0, "illegal words");
    end
  endtask : t_assist

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    t_reset;
    t_codes;
    t_assist;
    run_job(5'h01, 8'h28, 1'b1);
    tally_and_finish;
  end

  // Cuts a hang short well past the expected run of about a thousand cycles.
  initial
  begin
    #2000000;
    mismatches++;
    tally_and_finish;
  end
endmodule : tb_top
